// [hw/bawd_cfg.svh]
`ifndef BAWD_CFG_SVH
`define BAWD_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define BAWD_OFS_CTRL 8'h00
`define BAWD_OFS_MEMWIN 8'h04
`define BAWD_OFS_PFWIN 8'h08
`define BAWD_OFS_PFBASEHI 8'h0c
`define BAWD_OFS_PFLIMHI 8'h10
`define BAWD_OFS_IOWIN 8'h14
`define BAWD_OFS_IOHI 8'h18
`define BAWD_OFS_PFCFG 8'h1c
`define BAWD_OFS_STATUS 8'h20

// ----------------------------------------------------------------
// Control register bits
// ----------------------------------------------------------------
`define BAWD_CTRL_IOE 0
`define BAWD_CTRL_MSE 1
`define BAWD_CTRL_BME 2
`define BAWD_CTRL_ISA 3
`define BAWD_CTRL_VGA 4
`define BAWD_CTRL_VGA16 5
`define BAWD_CTRL_MASK 32'h0000003f

// ----------------------------------------------------------------
// Window field layouts and masks
// ----------------------------------------------------------------
`define BAWD_MEMWIN_MASK 32'h0fff0fff
`define BAWD_IOWIN_MASK 32'h000f000f
`define BAWD_PFCFG_MASK 32'h3fffffff

// ----------------------------------------------------------------
// Reset values: every window starts disabled (base above limit)
// ----------------------------------------------------------------
`define BAWD_RST_CTRL 32'h00000000
`define BAWD_RST_MEMWIN 32'h00000fff
`define BAWD_RST_PFWIN 32'h00000fff
`define BAWD_RST_PFBASEHI 32'h00000000
`define BAWD_RST_PFLIMHI 32'h00000000
`define BAWD_RST_IOWIN 32'h0000000f
`define BAWD_RST_IOHI 32'h00000000
`define BAWD_RST_PFCFG 32'h08020004

// ----------------------------------------------------------------
// PCI bus command codes
// ----------------------------------------------------------------
`define BAWD_CMD_IORD 4'h2
`define BAWD_CMD_IOWR 4'h3
`define BAWD_CMD_MEMRD 4'h6
`define BAWD_CMD_MEMWR 4'h7
`define BAWD_CMD_MRM 4'hc
`define BAWD_CMD_MRL 4'he
`define BAWD_CMD_MWI 4'hf

// ----------------------------------------------------------------
// Fixed legacy ranges
// ----------------------------------------------------------------
`define BAWD_VGA_MEM_LO 32'h000a0000
`define BAWD_VGA_MEM_HI 32'h000bffff
`define BAWD_VGA_IO_A_LO 10'h3b0
`define BAWD_VGA_IO_A_HI 10'h3bb
`define BAWD_VGA_IO_B_LO 10'h3c0
`define BAWD_VGA_IO_B_HI 10'h3df
`define BAWD_ISA_TOP64K 16'h0000

`endif

// [hw/bawd_pkg.sv]
`default_nettype none
package bawd_pkg;
	// Decode outcome of one transaction
	typedef enum logic [2:0] {
		RES_FWD = 3'b001,
		RES_UR = 3'b010,
		RES_IGN = 3'b100
	} bawd_result_e;

	typedef logic [31:0] bawd_word_t;
endpackage
`default_nettype wire

// [hw/bawd_window_cmp.sv]
`default_nettype none
// Inclusive base/limit window; empty when base exceeds limit
module bawd_window_cmp #(
	parameter int W = 32
) (
	input wire logic [W-1:0] base,
	input wire logic [W-1:0] limit,
	input wire logic [W-1:0] addr,
	output logic enabled,
	output logic hit
);
	// Full-width compares, so a window may span any boundary
	assign enabled = (base <= limit);
	assign hit = enabled && (addr >= base) && (addr <= limit);
endmodule
`default_nettype wire

// [hw/bawd_prefetch_sel.sv]
`default_nettype none
`include "bawd_cfg.svh"
// Chooses whether and how much to prefetch for an upstream read
module bawd_prefetch_sel (
	input wire logic [3:0] cmd,
	input wire logic targetPrefetchable,
	input wire logic [9:0] readBytes,
	input wire logic [9:0] lineBytes,
	input wire logic [9:0] multipleBytes,
	output logic doPrefetch,
	output logic [9:0] prefetchBytes
);
	wire logic isLine;
	wire logic isMultiple;
	wire logic isPlain;

	// Plain read may touch side effects, so only prefetchable space allows it
	assign isLine = (cmd == `BAWD_CMD_MRL);
	assign isMultiple = (cmd == `BAWD_CMD_MRM);
	assign isPlain = (cmd == `BAWD_CMD_MEMRD);
	assign doPrefetch = isLine || isMultiple || (isPlain && targetPrefetchable);
	assign prefetchBytes = isMultiple ? multipleBytes :
		isLine ? lineBytes :
		(isPlain && targetPrefetchable) ? readBytes : 10'h000;
endmodule
`default_nettype wire

// [hw/bawd_decode.sv]
// Local design decisions: the address map and the APB interface to the registers.
`default_nettype none
`include "bawd_cfg.svh"
// Address window decode for a PCIe-to-PCI bridge, with APB configuration
module bawd_decode (
	input wire logic clk_sys,
	input wire logic resetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Downstream request from the PCIe side
	input wire logic dnValid,
	input wire logic dnIsIo,
	input wire logic dnLongAddr,
	input wire logic [63:0] dnAddr,
	input wire logic [12:0] dnByteCount,
	output logic dnDone,
	output logic dnForward,
	output logic dnUnsupported,
	output logic [12:0] dnReadBytes,
	// Upstream transaction seen on the PCI bus
	input wire logic upValid,
	input wire logic [3:0] upCmd,
	input wire logic [63:0] upAddr,
	input wire logic upTargetPrefetchable,
	output logic upDone,
	output logic upForward,
	output logic upIgnore,
	output logic upPrefetch,
	output logic [9:0] upPrefetchBytes
);
	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic [31:0] ctrl;
	logic [31:0] memWin;
	logic [31:0] pfWin;
	logic [31:0] pfBaseHi;
	logic [31:0] pfLimHi;
	logic [31:0] ioWin;
	logic [31:0] ioHi;
	logic [31:0] pfCfg;
	logic [2:0] lastDnResult;
	logic [2:0] lastUpResult;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	wire logic apbSetup;
	wire logic apbWrite;
	wire logic selCtrl;
	wire logic selMemWin;
	wire logic selPfWin;
	wire logic selPfBaseHi;
	wire logic selPfLimHi;
	wire logic selIoWin;
	wire logic selIoHi;
	wire logic selPfCfg;
	wire logic selStatus;
	wire logic addrMapped;
	wire logic [31:0] strobeMask;
	wire logic [31:0] statusWord;
	wire logic [31:0] readMux;
	wire logic npEnabled;
	wire logic pfEnabled;
	wire logic ioEnabled;

	assign apbSetup = psel && !penable;
	// Write lands at the edge where the access phase sees pready
	assign apbWrite = psel && penable && pready && pwrite;
	assign selCtrl = (paddr == `BAWD_OFS_CTRL);
	assign selMemWin = (paddr == `BAWD_OFS_MEMWIN);
	assign selPfWin = (paddr == `BAWD_OFS_PFWIN);
	assign selPfBaseHi = (paddr == `BAWD_OFS_PFBASEHI);
	assign selPfLimHi = (paddr == `BAWD_OFS_PFLIMHI);
	assign selIoWin = (paddr == `BAWD_OFS_IOWIN);
	assign selIoHi = (paddr == `BAWD_OFS_IOHI);
	assign selPfCfg = (paddr == `BAWD_OFS_PFCFG);
	assign selStatus = (paddr == `BAWD_OFS_STATUS);
	assign addrMapped = selCtrl || selMemWin || selPfWin || selPfBaseHi || selPfLimHi ||
		selIoWin || selIoHi || selPfCfg || selStatus;
	assign strobeMask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

	// Byte-lane merge of write data into a register, masked to its fields
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [31:0] lanes, input logic [31:0] fields);
		merge = ((old & ~lanes) | (wd & lanes)) & fields;
	endfunction

	// Status readback shows decode health and the last outcomes
	assign statusWord = {21'h000000, ioEnabled, pfEnabled, npEnabled,
		1'b0, lastUpResult, 1'b0, lastDnResult};

	// Read mux, zero for unmapped and status reads of nothing
	assign readMux = selCtrl ? ctrl :
		selMemWin ? memWin :
		selPfWin ? pfWin :
		selPfBaseHi ? pfBaseHi :
		selPfLimHi ? pfLimHi :
		selIoWin ? ioWin :
		selIoHi ? ioHi :
		selPfCfg ? pfCfg :
		selStatus ? statusWord : 32'h00000000;

	// Slave answers in the first access cycle; error flags unmapped or status writes
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready <= apbSetup;
			prdata <= (apbSetup && !pwrite) ? readMux : 32'h00000000;
			pslverr <= apbSetup && (!addrMapped || (pwrite && selStatus));
		end
	end

	// Register writes
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ctrl <= `BAWD_RST_CTRL;
			memWin <= `BAWD_RST_MEMWIN;
			pfWin <= `BAWD_RST_PFWIN;
			pfBaseHi <= `BAWD_RST_PFBASEHI;
			pfLimHi <= `BAWD_RST_PFLIMHI;
			ioWin <= `BAWD_RST_IOWIN;
			ioHi <= `BAWD_RST_IOHI;
			pfCfg <= `BAWD_RST_PFCFG;
		end else if (apbWrite) begin
			if (selCtrl) ctrl <= merge(ctrl, pwdata, strobeMask, `BAWD_CTRL_MASK);
			if (selMemWin) memWin <= merge(memWin, pwdata, strobeMask, `BAWD_MEMWIN_MASK);
			if (selPfWin) pfWin <= merge(pfWin, pwdata, strobeMask, `BAWD_MEMWIN_MASK);
			if (selPfBaseHi) pfBaseHi <= merge(pfBaseHi, pwdata, strobeMask, 32'hffffffff);
			if (selPfLimHi) pfLimHi <= merge(pfLimHi, pwdata, strobeMask, 32'hffffffff);
			if (selIoWin) ioWin <= merge(ioWin, pwdata, strobeMask, `BAWD_IOWIN_MASK);
			if (selIoHi) ioHi <= merge(ioHi, pwdata, strobeMask, 32'hffffffff);
			if (selPfCfg) pfCfg <= merge(pfCfg, pwdata, strobeMask, `BAWD_PFCFG_MASK);
		end
	end

	// ----------------------------------------------------------------
	// Control bits and window bounds
	// ----------------------------------------------------------------
	wire logic ioSpaceEnable;
	wire logic memory_space_enable;
	wire logic bus_master_enable;
	wire logic isaEnable;
	wire logic vgaEnable;
	wire logic vga16BitEnable;
	wire logic [31:0] npBase;
	wire logic [31:0] npLimit;
	wire logic [63:0] pfBase;
	wire logic [63:0] pfLimit;
	wire logic [31:0] ioBase;
	wire logic [31:0] ioLimit;

	assign ioSpaceEnable = ctrl[`BAWD_CTRL_IOE];
	assign memory_space_enable = ctrl[`BAWD_CTRL_MSE];
	assign bus_master_enable = ctrl[`BAWD_CTRL_BME];
	assign isaEnable = ctrl[`BAWD_CTRL_ISA];
	assign vgaEnable = ctrl[`BAWD_CTRL_VGA];
	assign vga16BitEnable = ctrl[`BAWD_CTRL_VGA16];

	// Low 20 bits fixed: 1 MB aligned base, limit fills to the top of its MB
	assign npBase = {memWin[11:0], 20'h00000};
	assign npLimit = {memWin[27:16], 20'hfffff};
	// Upper 32 bits take part, so the disable test spans all four fields
	assign pfBase = {pfBaseHi, pfWin[11:0], 20'h00000};
	assign pfLimit = {pfLimHi, pfWin[27:16], 20'hfffff};
	// 4 KB aligned I/O window with its upper 16 bits
	assign ioBase = {ioHi[15:0], ioWin[3:0], 12'h000};
	assign ioLimit = {ioHi[31:16], ioWin[19:16], 12'hfff};

	// ----------------------------------------------------------------
	// Window compares for both directions
	// ----------------------------------------------------------------
	wire logic [63:0] dnAddrEff;
	wire logic dnNpHit;
	wire logic dnPfHit;
	wire logic dnIoHit;
	wire logic upNpHit;
	wire logic upPfHit;
	wire logic upIoHit;

	// Short format carries no upper address; treat it as zero
	assign dnAddrEff = dnLongAddr ? dnAddr : {32'h00000000, dnAddr[31:0]};

	bawd_window_cmp #(.W(32)) u_dnNp (
		.base(npBase), .limit(npLimit), .addr(dnAddrEff[31:0]),
		.enabled(npEnabled), .hit(dnNpHit)
	);
	bawd_window_cmp #(.W(64)) u_dnPf (
		.base(pfBase), .limit(pfLimit), .addr(dnAddrEff),
		.enabled(pfEnabled), .hit(dnPfHit)
	);
	bawd_window_cmp #(.W(32)) u_dnIo (
		.base(ioBase), .limit(ioLimit), .addr(dnAddr[31:0]),
		.enabled(ioEnabled), .hit(dnIoHit)
	);
	bawd_window_cmp #(.W(32)) u_upNp (
		.base(npBase), .limit(npLimit), .addr(upAddr[31:0]),
		.enabled(), .hit(upNpHit)
	);
	bawd_window_cmp #(.W(64)) u_upPf (
		.base(pfBase), .limit(pfLimit), .addr(upAddr),
		.enabled(), .hit(upPfHit)
	);
	bawd_window_cmp #(.W(32)) u_upIo (
		.base(ioBase), .limit(ioLimit), .addr(upAddr[31:0]),
		.enabled(), .hit(upIoHit)
	);

	// ----------------------------------------------------------------
	// Legacy VGA and ISA ranges
	// ----------------------------------------------------------------
	wire logic dnVgaMem;
	wire logic upVgaMem;
	wire logic dnVgaIo;
	wire logic upVgaIo;
	wire logic dnIsaTop;
	wire logic upIsaTop;
	wire logic upAbove4G;

	// Frame buffer lives below 4 GB only
	assign dnVgaMem = vgaEnable && (dnAddrEff[63:32] == 32'h00000000) &&
		(dnAddrEff[31:0] >= `BAWD_VGA_MEM_LO) && (dnAddrEff[31:0] <= `BAWD_VGA_MEM_HI);
	assign upAbove4G = (upAddr[63:32] != 32'h00000000);
	assign upVgaMem = vgaEnable && !upAbove4G &&
		(upAddr[31:0] >= `BAWD_VGA_MEM_LO) && (upAddr[31:0] <= `BAWD_VGA_MEM_HI);

	// Register decode ignores bits 31:10 unless 16-bit decode is chosen
	function automatic logic vgaIoMatch(input logic [31:0] a, input logic full16);
		logic inRange;
		inRange = ((a[9:0] >= `BAWD_VGA_IO_A_LO) && (a[9:0] <= `BAWD_VGA_IO_A_HI)) ||
			((a[9:0] >= `BAWD_VGA_IO_B_LO) && (a[9:0] <= `BAWD_VGA_IO_B_HI));
		vgaIoMatch = inRange && (!full16 || (a[31:10] == 22'h000000));
	endfunction
	assign dnVgaIo = vgaEnable && vgaIoMatch(dnAddr[31:0], vga16BitEnable);
	assign upVgaIo = vgaEnable && vgaIoMatch(upAddr[31:0], vga16BitEnable);

	// Top 768 bytes of a 1 KB block: offset bits 9:8 not both zero
	assign dnIsaTop = isaEnable && (dnAddr[31:16] == `BAWD_ISA_TOP64K) &&
		(dnAddr[9:8] != 2'b00);
	assign upIsaTop = isaEnable && (upAddr[31:16] == `BAWD_ISA_TOP64K) &&
		(upAddr[9:8] != 2'b00);

	// ----------------------------------------------------------------
	// Downstream decision
	// ----------------------------------------------------------------
	wire logic dnMemClaim;
	wire logic dnIoClaim;
	wire logic [2:0] dnResult;

	// Short format may reach the low part of the prefetchable window only,
	// long format only the part at or above 4 GB
	assign dnMemClaim = (!dnLongAddr && dnNpHit) ||
		(dnPfHit && (dnLongAddr == (dnAddrEff[63:32] != 32'h00000000))) ||
		dnVgaMem;
	assign dnIoClaim = (dnIoHit && !dnIsaTop) || dnVgaIo;
	assign dnResult = dnIsIo ?
		((ioSpaceEnable && dnIoClaim) ? bawd_pkg::RES_FWD : bawd_pkg::RES_UR) :
		((memory_space_enable && dnMemClaim) ? bawd_pkg::RES_FWD :
		bawd_pkg::RES_UR);

	// One-cycle registered answer per request
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			dnDone <= 1'b0;
			dnForward <= 1'b0;
			dnUnsupported <= 1'b0;
			dnReadBytes <= 13'h0000;
		end else begin
			dnDone <= dnValid;
			dnForward <= dnValid && (dnResult == bawd_pkg::RES_FWD);
			dnUnsupported <= dnValid && (dnResult == bawd_pkg::RES_UR);
			// Exactly what the request asked, never rounded up
			dnReadBytes <= (dnValid && !dnIsIo && dnResult == bawd_pkg::RES_FWD) ?
				dnByteCount : 13'h0000;
		end
	end

	// ----------------------------------------------------------------
	// Upstream decision (inverse decode)
	// ----------------------------------------------------------------
	wire logic upIsIo;
	wire logic upMemInside;
	wire logic upIoInside;
	wire logic upPassMem;
	wire logic upPassIo;
	wire logic [2:0] upResult;
	wire logic upPfWanted;
	wire logic [9:0] upPfBytes;

	assign upIsIo = (upCmd == `BAWD_CMD_IORD) || (upCmd == `BAWD_CMD_IOWR);
	assign upMemInside = (upNpHit && !upAbove4G) || upPfHit || upVgaMem;
	// ISA top range goes up even when inside the I/O window
	assign upIoInside = (upIoHit && !upIsaTop) || upVgaIo;
	// With decode enables off nothing is claimed, so everything passes up while bus master is enabled
	assign upPassMem = !memory_space_enable || !upMemInside;
	assign upPassIo = !ioSpaceEnable || !upIoInside;
	assign upResult = !bus_master_enable ? bawd_pkg::RES_IGN :
		(upIsIo ? (upPassIo ? bawd_pkg::RES_FWD : bawd_pkg::RES_IGN) :
		(upPassMem ? bawd_pkg::RES_FWD : bawd_pkg::RES_IGN));

	bawd_prefetch_sel u_prefetch (
		.cmd(upCmd),
		.targetPrefetchable(upTargetPrefetchable),
		.readBytes(pfCfg[9:0]),
		.lineBytes(pfCfg[19:10]),
		.multipleBytes(pfCfg[29:20]),
		.doPrefetch(upPfWanted),
		.prefetchBytes(upPfBytes)
	);

	// Registered upstream answer; prefetch only for forwarded reads
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			upDone <= 1'b0;
			upForward <= 1'b0;
			upIgnore <= 1'b0;
			upPrefetch <= 1'b0;
			upPrefetchBytes <= 10'h000;
		end else begin
			upDone <= upValid;
			upForward <= upValid && (upResult == bawd_pkg::RES_FWD);
			upIgnore <= upValid && (upResult == bawd_pkg::RES_IGN);
			upPrefetch <= upValid && (upResult == bawd_pkg::RES_FWD) && !upIsIo &&
				upPfWanted;
			upPrefetchBytes <= (upValid && (upResult == bawd_pkg::RES_FWD) && !upIsIo) ?
				upPfBytes : 10'h000;
		end
	end

	// ----------------------------------------------------------------
	// Last outcome capture for status readback
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			lastDnResult <= 3'h0;
			lastUpResult <= 3'h0;
		end else begin
			if (dnValid) lastDnResult <= dnResult;
			if (upValid) lastUpResult <= upResult;
		end
	end
endmodule
`default_nettype wire

// [bench/bawd_decode_chk.sv]
`default_nettype none
// ----------------------------------------
// Decode answer and gating checks
// ----------------------------------------
module bawd_decode_chk (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic dnValid,
	input wire logic dnIsIo,
	input wire logic [12:0] dnByteCount,
	input wire logic dnDone,
	input wire logic dnForward,
	input wire logic dnUnsupported,
	input wire logic [12:0] dnReadBytes,
	input wire logic upValid,
	input wire logic [3:0] upCmd,
	input wire logic upDone,
	input wire logic upForward,
	input wire logic upIgnore,
	input wire logic upPrefetch,
	input wire logic [9:0] upPrefetchBytes
);
	timeunit 1ns / 1ps;
	logic [2:0] enables;
	logic ctrlWr;
	logic upIsMem;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// Shadow of the enable bits, so gating is judged without seeing the register file
	assign ctrlWr = psel && penable && pready && pwrite && paddr == 8'h00 && pstrb[0];
	assign upIsMem = upCmd != 4'h2 && upCmd != 4'h3;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			enables <= 3'h0;
		end else if (ctrlWr) begin
			enables <= pwdata[2:0];
		end
	end
	a_apb_ready: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_dn_answer: assert property (dnValid |=> dnDone && (dnForward ^ dnUnsupported))
		else $error("downstream answer missing or ambiguous");
	a_up_answer: assert property (upValid |=> upDone && (upForward ^ upIgnore))
		else $error("upstream answer missing or ambiguous");
	a_mem_off_ur: assert property (dnValid && !dnIsIo && !enables[1] |=> dnUnsupported)
		else $error("memory request not refused while disabled");
	a_io_off_ur: assert property (dnValid && dnIsIo && !enables[0] |=> dnUnsupported)
		else $error("io request not refused while disabled");
	a_master_off_ign: assert property (upValid && !enables[2] |=> upIgnore && !upPrefetch)
		else $error("bus transaction not ignored without master enable");
	a_up_mem_pass: assert property (upValid && upIsMem && enables[2] && !enables[1] |=> upForward)
		else $error("memory not passed upstream while memory disabled");
	a_read_bytes: assert property (dnValid && !dnIsIo |=>
		dnReadBytes == (dnForward ? $past(dnByteCount) : 13'h0))
		else $error("downstream read size differs from request");
	a_write_no_pf: assert property (upValid && upCmd == 4'h7 |=> !upPrefetch && upPrefetchBytes == 10'h0)
		else $error("prefetch on a write");
	a_pf_forward: assert property (upPrefetch |-> upForward && upPrefetchBytes != 10'h0)
		else $error("prefetch without forward or size");
	c_dn_fwd: cover property (dnForward);
	c_up_pf: cover property (upPrefetch);
	c_up_ign: cover property (upIgnore && enables[2]);
endmodule
`default_nettype wire

// [bench/bawd_link_model.sv]
`default_nettype none
// ----------------------------------------
// Link side and bus initiator model
// ----------------------------------------
module bawd_link_model (
	input wire logic clk_sys,
	output logic dnValid,
	output logic dnIsIo,
	output logic dnLongAddr,
	output logic [63:0] dnAddr,
	output logic [12:0] dnByteCount,
	output logic upValid,
	output logic [3:0] upCmd,
	output logic [63:0] upAddr,
	output logic upTargetPrefetchable,
	input wire logic dnDone,
	input wire logic upDone
);
	timeunit 1ns / 1ps;
	initial begin
		dnValid = 1'b0;
		dnIsIo = 1'b0;
		dnLongAddr = 1'b0;
		dnAddr = 64'h0;
		dnByteCount = 13'h0;
		upValid = 1'b0;
		upCmd = 4'h0;
		upAddr = 64'h0;
		upTargetPrefetchable = 1'b0;
	end
	// One pulse, then an inverted address so stale values look wrong
	task automatic dnReq(input logic io, input logic lng, input logic [63:0] a, output logic ok);
		@(posedge clk_sys);
		dnValid <= 1'b1;
		dnIsIo <= io;
		dnLongAddr <= lng;
		dnAddr <= a;
		dnByteCount <= 13'h1fff; // All bits set
		@(posedge clk_sys);
		dnValid <= 1'b0;
		dnAddr <= ~a;
		ok = 1'b0;
		for (int i = 0; i < 4 && !ok; i++) begin
			@(negedge clk_sys);
			ok = dnDone;
		end
	endtask
	task automatic upReq(input logic [3:0] c, input logic [63:0] a, input logic tp, output logic ok);
		@(posedge clk_sys);
		upValid <= 1'b1;
		upCmd <= c;
		upAddr <= a;
		upTargetPrefetchable <= tp;
		@(posedge clk_sys);
		upValid <= 1'b0;
		upAddr <= ~a;
		ok = 1'b0;
		for (int i = 0; i < 4 && !ok; i++) begin
			@(negedge clk_sys);
			ok = upDone;
		end
	endtask
endmodule
`default_nettype wire

// [bench/tb.sv]
`default_nettype none
`include "bawd_cfg.svh"
// ----------------------------------------
// Window decode bench
// ----------------------------------------
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb, upCmd;
	logic dnValid, dnIsIo, dnLongAddr, dnDone, dnForward, dnUnsupported;
	logic [63:0] dnAddr, upAddr;
	logic [12:0] dnByteCount, dnReadBytes;
	logic upValid, upTargetPrefetchable, upDone, upForward, upIgnore, upPrefetch;
	logic [9:0] upPrefetchBytes;
	int fails = 0;
	int samples_checked = 0;
	always #20 clk_sys = ~clk_sys;
	bawd_decode DUT (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .dnValid(dnValid), .dnIsIo(dnIsIo),
		.dnLongAddr(dnLongAddr), .dnAddr(dnAddr), .dnByteCount(dnByteCount), .dnDone(dnDone),
		.dnForward(dnForward), .dnUnsupported(dnUnsupported), .dnReadBytes(dnReadBytes),
		.upValid(upValid), .upCmd(upCmd), .upAddr(upAddr),
		.upTargetPrefetchable(upTargetPrefetchable), .upDone(upDone), .upForward(upForward),
		.upIgnore(upIgnore), .upPrefetch(upPrefetch), .upPrefetchBytes(upPrefetchBytes));
	bawd_link_model lm (.clk_sys(clk_sys), .dnValid(dnValid), .dnIsIo(dnIsIo),
		.dnLongAddr(dnLongAddr), .dnAddr(dnAddr), .dnByteCount(dnByteCount), .upValid(upValid),
		.upCmd(upCmd), .upAddr(upAddr), .upTargetPrefetchable(upTargetPrefetchable),
		.dnDone(dnDone), .upDone(upDone));
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic timeout();
		fails++;
		$display("BAD wait expected done seen none");
		final_report();
	endtask
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// Held until ready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic s);
		int i;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		for (i = 0; i < 8; i++) begin
			@(posedge clk_sys);
			if (pready === 1'b1) break;
		end
		q = prdata;
		s = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 8) timeout();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
		logic [31:0] q;
		logic s;
		apb(1'b1, a, d, q, s);
		chk("pslverr", e, s);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e);
		logic [31:0] q;
		logic s;
		apb(1'b0, a, 32'h0, q, s);
		chk("prdata", d, q);
		chk("pslverr", e, s);
	endtask
	task automatic dn(input logic io, input logic lng, input logic [63:0] a, input logic f);
		logic ok;
		lm.dnReq(io, lng, a, ok);
		if (!ok) timeout();
		chk("dnForward", f, dnForward);
		chk("dnUnsupported", !f, dnUnsupported);
		chk("dnReadBytes", (f && !io) ? 13'h1fff : 13'h0, dnReadBytes);
	endtask
	task automatic up(input logic [3:0] c, input logic [63:0] a, input logic tp, input logic f,
		input logic [9:0] pb);
		logic ok;
		lm.upReq(c, a, tp, ok);
		if (!ok) timeout();
		chk("upForward", f, upForward);
		chk("upIgnore", !f, upIgnore);
		chk("upPrefetch", pb != 10'h0, upPrefetch);
		chk("upPrefetchBytes", pb, upPrefetchBytes);
	endtask
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		pstrb = 4'hf;
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		// Reset values, refused accesses, decode enables off (bus master enabled for the last two)
		rd(`BAWD_OFS_CTRL, `BAWD_RST_CTRL, 1'b0);
		rd(`BAWD_OFS_MEMWIN, 32'hfff, 1'b0);
		rd(`BAWD_OFS_PFCFG, 32'h08020004, 1'b0);
		rd(8'h24, 32'h0, 1'b1);
		wr(`BAWD_OFS_STATUS, 32'h0, 1'b1);
		dn(1'b0, 1'b0, 64'h0, 1'b0);
		dn(1'b1, 1'b0, 64'h1000, 1'b0);
		up(`BAWD_CMD_MEMRD, 64'h0, 1'b0, 1'b0, 10'h0);
		up(`BAWD_CMD_IORD, 64'h0, 1'b0, 1'b0, 10'h0);
		wr(`BAWD_OFS_CTRL, 32'h4, 1'b0);
		up(`BAWD_CMD_MEMWR, 64'h5000_0000, 1'b0, 1'b1, 10'h0);
		up(`BAWD_CMD_IOWR, 64'h1000, 1'b0, 1'b1, 10'h0);
		$display("test disabled done");
		// Window 0x1000_0000 to 0x1fff_ffff
		wr(`BAWD_OFS_MEMWIN, 32'h01ff0100, 1'b0);
		rd(`BAWD_OFS_MEMWIN, 32'h01ff0100, 1'b0);
		wr(`BAWD_OFS_CTRL, 32'h7, 1'b0);
		dn(1'b0, 1'b0, 64'h1000_0000, 1'b1);
		dn(1'b0, 1'b0, 64'h1fff_ffff, 1'b1);
		dn(1'b0, 1'b0, 64'h0fff_ffff, 1'b0);
		dn(1'b0, 1'b0, 64'h2000_0000, 1'b0);
		up(`BAWD_CMD_MEMWR, 64'h1000_0000, 1'b0, 1'b0, 10'h0);
		$display("test memory window done");
		// Distinct sizes so a swapped command shows
		wr(`BAWD_OFS_PFCFG, 32'h10030008, 1'b0);
		up(`BAWD_CMD_MEMRD, 64'h3000_0000, 1'b0, 1'b1, 10'h0);
		up(`BAWD_CMD_MRL, 64'h3000_0000, 1'b0, 1'b1, 10'h0c0);
		up(`BAWD_CMD_MRM, 64'h3000_0000, 1'b0, 1'b1, 10'h100);
		up(`BAWD_CMD_MEMRD, 64'h3000_0000, 1'b1, 1'b1, 10'h008);
		up(`BAWD_CMD_MRL, 64'h3000_0000, 1'b1, 1'b1, 10'h0c0);
		$display("test prefetch done");
		// Prefetchable window 0xf000_0000 to 0x1_00ff_ffff, across 4 GB
		wr(`BAWD_OFS_PFWIN, 32'h000f0f00, 1'b0);
		wr(`BAWD_OFS_PFLIMHI, 32'h1, 1'b0);
		dn(1'b0, 1'b0, 64'hf000_0000, 1'b1);
		dn(1'b0, 1'b1, 64'h1_0000_0000, 1'b1);
		dn(1'b0, 1'b1, 64'h1_00ff_ffff, 1'b1);
		dn(1'b0, 1'b1, 64'h1_0100_0000, 1'b0);
		dn(1'b0, 1'b1, 64'hf000_0000, 1'b0);
		up(`BAWD_CMD_MEMWR, 64'h1_0000_0000, 1'b0, 1'b0, 10'h0);
		wr(`BAWD_OFS_PFBASEHI, 32'h2, 1'b0);
		dn(1'b0, 1'b1, 64'h1_0000_0000, 1'b0);
		dn(1'b0, 1'b0, 64'h1000_0000, 1'b1);
		up(`BAWD_CMD_MEMWR, 64'h1_1000_0000, 1'b0, 1'b1, 10'h0);
		$display("test prefetchable done");
		// I/O window 0x1000 to 0x2fff
		wr(`BAWD_OFS_IOWIN, 32'h00020001, 1'b0);
		dn(1'b1, 1'b0, 64'h1000, 1'b1);
		dn(1'b1, 1'b0, 64'h2fff, 1'b1);
		dn(1'b1, 1'b0, 64'h3000, 1'b0);
		up(`BAWD_CMD_IOWR, 64'h1000, 1'b0, 1'b0, 10'h0);
		wr(`BAWD_OFS_IOHI, 32'h1, 1'b0);
		dn(1'b1, 1'b0, 64'h1000, 1'b0);
		wr(`BAWD_OFS_IOHI, 32'h0, 1'b0);
		wr(`BAWD_OFS_CTRL, 32'hf, 1'b0);
		dn(1'b1, 1'b0, 64'h1100, 1'b0);
		dn(1'b1, 1'b0, 64'h10ff, 1'b1);
		up(`BAWD_CMD_IORD, 64'h1100, 1'b0, 1'b1, 10'h0);
		$display("test io done");
		// Frame buffer range
		wr(`BAWD_OFS_CTRL, 32'h17, 1'b0);
		dn(1'b0, 1'b0, 64'ha_0000, 1'b1);
		dn(1'b0, 1'b0, 64'hb_ffff, 1'b1);
		dn(1'b0, 1'b0, 64'hc_0000, 1'b0);
		up(`BAWD_CMD_MEMWR, 64'ha_0000, 1'b0, 1'b0, 10'h0);
		$display("test frame buffer done");
		final_report();
	end
endmodule
bind bawd_decode bawd_decode_chk u_chk (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.pready(pready), .dnValid(dnValid), .dnIsIo(dnIsIo), .dnByteCount(dnByteCount),
	.dnDone(dnDone), .dnForward(dnForward), .dnUnsupported(dnUnsupported),
	.dnReadBytes(dnReadBytes), .upValid(upValid), .upCmd(upCmd), .upDone(upDone),
	.upForward(upForward), .upIgnore(upIgnore), .upPrefetch(upPrefetch),
	.upPrefetchBytes(upPrefetchBytes));
`default_nettype wire
